/* logic/sar_ctrl_pkg.sv */
// constants and types for the converter control and result readout
// Function
// - a conversion begins only from the convert-start input
// - conversion starts when acquisition is done, power-down is low and convert-start falls, or stays low in impulse mode
// - a running conversion is never restarted or aborted
// - chip-select and read-strobe never gate or trigger a conversion
// - at the end of approximation form the code and drop busy
// - impulse mode restarts itself while convert-start stays low
// - self-restart exists only in impulse mode
// - impulse mode powers down after each conversion, interface stays live
// - coding select applies only in the 16- and 8-bit parallel modes
// - outputs float unless chip-select and read-strobe are both low
// - serial mode leaves the parallel data pins undriven; no serial port is built
// - parallel bus widths of 18, 16 or 8 bits by mode inputs
// - result readable after conversion or during the next one
// - reference buffer on when its power-down input is low
package sar_ctrl_pkg;
  localparam int RES_BITS = 18;
  localparam int CLK_HZ = 50_000_000;
  // minimum acquisition time in ns, and its count rounded up
  localparam int ACQ_NS = 400;
  localparam int ACQ_CYC = (ACQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // one cycle per bit decision plus one to form the code
  localparam int CONV_CYC = RES_BITS + 1;
  localparam logic [1:0] MODE_P18 = 2'h0;
  localparam logic [1:0] MODE_P16 = 2'h1;
  localparam logic [1:0] MODE_P8 = 2'h2;
  localparam logic [1:0] MODE_SER = 2'h3;
  localparam logic [1:0] SPEED_WARP = 2'h0;
  localparam logic [1:0] SPEED_NORMAL = 2'h1;
  localparam logic [1:0] SPEED_IMPULSE = 2'h2;
  localparam logic [RES_BITS-1:0] SIGN_FLIP = 18'h20000;
  typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_DONE} conv_state_t;
endpackage

/* logic/sar_ctrl_if.sv */
// bundle between the conversion sequencer and the readout port
interface sar_ctrl_if;
  logic result_load;
  logic [sar_ctrl_pkg::RES_BITS-1:0] result_code;
  logic converting;
  modport seq (output result_load, output result_code, output converting);
  modport rd (input result_load, input result_code, input converting);
endinterface

/* logic/sar_readout.sv */
// parallel result readout with coding and bus width selection
module sar_readout (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // from sequencer
  sar_ctrl_if.rd link,
  // host pins, already synchronised
  input wire logic cs_n_s,
  input wire logic rd_n_s,
  input wire logic byte_swap_s,
  input wire logic coding_select_s,
  input wire logic [1:0] interface_sel_s,
  // data pins
  output logic [17:0] data_o,
  output logic [17:0] data_oe
);
  logic [17:0] held_r;
  logic [17:0] coded;
  logic [17:0] shaped;
  logic drive;

  // result register keeps the last code into the next conversion
  always_ff @(posedge clk_sys) begin
    if (!rst_n) held_r <= 18'h00000;
    else if (link.result_load) held_r <= link.result_code;
  end

  // coding high means straight binary; low flips the sign bit except in 18-bit mode
  assign coded = (interface_sel_s == sar_ctrl_pkg::MODE_P18 || coding_select_s)
      ? held_r : held_r ^ sar_ctrl_pkg::SIGN_FLIP;
  // width selection; 16 bits give the top word, 8 bits a byte by byte_swap
  assign shaped = (interface_sel_s == sar_ctrl_pkg::MODE_P18) ? coded :
      (interface_sel_s == sar_ctrl_pkg::MODE_P16) ? {2'h0, coded[17:2]} :
      (interface_sel_s == sar_ctrl_pkg::MODE_P8) ?
        (byte_swap_s ? {10'h000, coded[9:2]} : {10'h000, coded[17:10]}) :
      18'h00000;
  // serial mode leaves the pins to the serial port, which is not built here
  assign drive = !cs_n_s && !rd_n_s
      && interface_sel_s != sar_ctrl_pkg::MODE_SER;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_o <= 18'h00000;
      data_oe <= 18'h00000;
    end else begin
      data_o <= shaped;
      data_oe <= drive ? 18'h3FFFF : 18'h00000;
    end
  end

  chk_float_when_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_n_s || rd_n_s) |=> data_oe == 18'h00000)
    else $error("data pins driven while deselected");
  chk_load_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    link.result_load |=> held_r == $past(link.result_code))
    else $error("result not held");
  chk_width_eight: assert property (@(posedge clk_sys) disable iff (!rst_n)
    interface_sel_s == sar_ctrl_pkg::MODE_P8 |=> data_o[17:8] == 10'h000)
    else $error("upper pins active in byte mode");
  chk_load_at_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    link.result_load |-> link.converting)
    else $error("result loaded outside a conversion");
endmodule

/* logic/sar_conv_ctrl.sv */
// top: conversion sequencing, busy, impulse self-restart and readout
module sar_conv_ctrl #(
  parameter int ACQ_CYCLES = sar_ctrl_pkg::ACQ_CYC,
  parameter int CONV_CYCLES = sar_ctrl_pkg::CONV_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // conversion control pins
  input wire logic convert_start_n,
  input wire logic power_down_input,
  input wire logic [1:0] speed_mode,
  input wire logic ref_buffer_power_down,
  // interface configuration pins
  input wire logic coding_select,
  input wire logic interface_sel_0,
  input wire logic interface_sel_1,
  input wire logic byte_swap,
  // host read strobes
  input wire logic cs_n,
  input wire logic rd_n,
  // comparator decision from the analog core
  input wire logic cmp_in,
  // status and analog controls
  output logic busy,
  output logic core_low_power,
  output logic ref_buf_enable,
  output logic sample_switch_closed,
  // data pins
  output logic [17:0] data_o,
  output logic [17:0] data_oe
);
  localparam int NSYNC = 10;
  // idle pin levels; power-down reads low so reset leaves no low-power blip
  localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h2EB;
  // last cycle at which busy must still be high after it rises
  localparam int BUSY_LAST = CONV_CYCLES - 1;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic [1:0] speed_meta_r;
  logic [1:0] speed_sync_r;
  logic cnv_n_s, cnv_n_prev_r, pd_s, cs_s, rd_s, cod_s, bsw_s, rbuf_s;
  logic [1:0] isel_s;
  sar_ctrl_pkg::conv_state_t state_r, state_nxt;
  logic [7:0] cnt_r;
  logic [17:0] sar_r;
  logic [4:0] bit_r;
  logic acq_done, start_edge, start_auto, start_go, impulse;
  sar_ctrl_if link();

  // every pin passes two flops before logic looks at it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= SYNC_IDLE;
      sync_r <= SYNC_IDLE;
    end else begin
      meta_r <= {convert_start_n, power_down_input, cs_n, rd_n,
                 coding_select, byte_swap, ref_buffer_power_down,
                 interface_sel_1, interface_sel_0, cmp_in};
      sync_r <= meta_r;
    end
  end
  assign {cnv_n_s, pd_s, cs_s, rd_s, cod_s, bsw_s, rbuf_s} = sync_r[9:3];
  assign isel_s = sync_r[2:1];

  // the speed strap is a pin as well; reset assumes normal speed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      speed_meta_r <= sar_ctrl_pkg::SPEED_NORMAL;
      speed_sync_r <= sar_ctrl_pkg::SPEED_NORMAL;
    end else begin
      speed_meta_r <= speed_mode;
      speed_sync_r <= speed_meta_r;
    end
  end

  // only the convert-start pin launches; strobes play no part
  // a start seen too early is dropped silently rather than queued
  assign impulse = speed_sync_r == sar_ctrl_pkg::SPEED_IMPULSE;
  assign acq_done = cnt_r >= 8'(ACQ_CYCLES);
  assign start_edge = cnv_n_prev_r && !cnv_n_s;
  assign start_auto = impulse && !cnv_n_s;
  assign start_go = acq_done && !pd_s && (start_edge || start_auto);

  // sequencer next state; conversion ignores convert-start and power-down
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sar_ctrl_pkg::ST_ACQ: begin
        if (start_go) state_nxt = sar_ctrl_pkg::ST_CONV;
      end
      sar_ctrl_pkg::ST_CONV: begin
        if (bit_r == 5'h00) state_nxt = sar_ctrl_pkg::ST_DONE;
      end
      sar_ctrl_pkg::ST_DONE: begin
        state_nxt = sar_ctrl_pkg::ST_ACQ;
      end
      default: state_nxt = sar_ctrl_pkg::ST_ACQ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= sar_ctrl_pkg::ST_ACQ;
      cnv_n_prev_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnv_n_prev_r <= cnv_n_s;
    end
  end

  // acquisition timer restarts when a conversion finishes
  // it saturates, so a long idle spell leaves the next start free
  always_ff @(posedge clk_sys) begin
    if (!rst_n) cnt_r <= 8'(ACQ_CYCLES);
    else if (state_r != sar_ctrl_pkg::ST_ACQ) cnt_r <= 8'h00;
    else if (!acq_done) cnt_r <= cnt_r + 8'h01;
  end

  // msb-first trial bits; a set bit is kept when the comparator agrees
  // the comparator is resynchronised like a pin, so the analog core
  // must hold each answer for two cycles before it is taken
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sar_r <= 18'h00000;
      bit_r <= 5'h00;
    end else if (state_r == sar_ctrl_pkg::ST_ACQ && start_go) begin
      sar_r <= 18'h20000;
      bit_r <= 5'(sar_ctrl_pkg::RES_BITS - 1);
    end else if (state_r == sar_ctrl_pkg::ST_CONV) begin
      sar_r[bit_r] <= sync_r[0];
      if (bit_r != 5'h00) begin
        sar_r[bit_r - 5'h01] <= 1'b1;
        bit_r <= bit_r - 5'h01;
      end
    end
  end

  // result handed to readout as busy falls
  assign link.result_load = state_r == sar_ctrl_pkg::ST_DONE;
  assign link.result_code = sar_r;
  assign link.converting = state_r != sar_ctrl_pkg::ST_ACQ;

  // busy covers the conversion up to the cycle the result is loaded
  // impulse mode parks the core in low power whenever it acquires
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy <= 1'b0;
      core_low_power <= 1'b0;
      ref_buf_enable <= 1'b0;
      sample_switch_closed <= 1'b1;
    end else begin
      busy <= state_nxt != sar_ctrl_pkg::ST_ACQ;
      core_low_power <= pd_s ||
          (impulse && state_nxt == sar_ctrl_pkg::ST_ACQ);
      ref_buf_enable <= !rbuf_s;
      sample_switch_closed <= state_nxt == sar_ctrl_pkg::ST_ACQ;
    end
  end

  // readout stays live in low power since it never looks at it
  sar_readout u_readout (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .link(link),
    .cs_n_s(cs_s),
    .rd_n_s(rd_s),
    .byte_swap_s(bsw_s),
    .coding_select_s(cod_s),
    .interface_sel_s(isel_s),
    .data_o(data_o),
    .data_oe(data_oe)
  );

  // checks of the sequencer, all on the system clock
  sequence s_conv_run;
    busy [*8];
  endsequence
  // last high sample of busy followed by its fall
  sequence s_busy_end;
    busy ##1 !busy;
  endsequence

  chk_busy_rises: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == sar_ctrl_pkg::ST_ACQ && start_go) |=> busy)
    else $error("busy missed start");
  chk_no_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(busy) |-> s_conv_run)
    else $error("conversion cut short");
  chk_busy_falls: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(busy) |-> ##BUSY_LAST s_busy_end)
    else $error("busy length wrong");
  chk_no_self_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!impulse && state_r == sar_ctrl_pkg::ST_ACQ && !start_edge)
      |-> state_nxt == sar_ctrl_pkg::ST_ACQ)
    else $error("self restart outside impulse");
  chk_auto_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (impulse && state_r == sar_ctrl_pkg::ST_ACQ && acq_done && !cnv_n_s
      && !pd_s) |=> state_r == sar_ctrl_pkg::ST_CONV)
    else $error("impulse restart missing");
  chk_low_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (impulse && $fell(busy)) |-> core_low_power)
    else $error("no low power after conversion");
  chk_ref_buf: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rbuf_s |=> !ref_buf_enable)
    else $error("reference buffer not off");
  chk_strobe_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == sar_ctrl_pkg::ST_ACQ && cnv_n_s)
      |=> state_r == sar_ctrl_pkg::ST_ACQ)
    else $error("conversion without start");
  chk_pd_no_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == sar_ctrl_pkg::ST_CONV && (pd_s || !cnv_n_s))
      |=> state_r != sar_ctrl_pkg::ST_ACQ)
    else $error("conversion aborted");
  chk_busy_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (busy && !link.result_load) |=> busy)
    else $error("busy dropped before result");
  chk_load_ends: assert property (@(posedge clk_sys) disable iff (!rst_n)
    link.result_load |=> !busy)
    else $error("busy high after result load");
  chk_switch_open: assert property (@(posedge clk_sys) disable iff (!rst_n)
    busy |-> !sample_switch_closed)
    else $error("sample switch closed while converting");
endmodule

/* bench/host_model.sv */
// host model: reads the parallel result bus with chip-select and strobe
module host_model (
  // clock
  input wire logic clk_sys,
  // result bus
  input wire logic [17:0] data_o,
  input wire logic [17:0] data_oe,
  // strobes
  output logic cs_n,
  output logic rd_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
  // strobes held five cycles, long enough for the registered enables;
  // reads during a conversion use the same five-cycle strobes as any other
  task automatic read(output logic [17:0] d, output logic [17:0] oe);
    @(negedge clk_sys);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    d = data_o;
    oe = data_oe;
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask
endmodule

/* bench/sar_conversion_control_readout_tb.sv */
// self-checking bench for the converter control and result readout
module sar_conversion_control_readout_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, convert_start_n, power_down_input, cmp_in;
  logic ref_buffer_power_down, coding_select, byte_swap, cs_n, rd_n;
  logic interface_sel_0, interface_sel_1, busy, core_low_power;
  logic ref_buf_enable, sample_switch_closed, was, lp;
  logic [1:0] speed_mode, md;
  logic [17:0] data_o, data_oe, rd_d, rd_oe, code, prev;
  logic [31:0] lfsr;
  int n_errors, check_count, cyc, nb;
  // acquisition shortened to two cycles to keep the run brief
  sar_conv_ctrl #(.ACQ_CYCLES(2)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .convert_start_n(convert_start_n), .power_down_input(power_down_input),
    .speed_mode(speed_mode), .ref_buffer_power_down(ref_buffer_power_down),
    .coding_select(coding_select), .interface_sel_0(interface_sel_0),
    .interface_sel_1(interface_sel_1), .byte_swap(byte_swap), .cs_n(cs_n),
    .rd_n(rd_n), .cmp_in(cmp_in), .busy(busy),
    .core_low_power(core_low_power), .ref_buf_enable(ref_buf_enable),
    .sample_switch_closed(sample_switch_closed), .data_o(data_o),
    .data_oe(data_oe));
  host_model host (.clk_sys(clk_sys), .data_o(data_o), .data_oe(data_oe),
    .cs_n(cs_n), .rd_n(rd_n));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ceiling far above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [17:0] s, input logic [17:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // bus value for a code in a given width and coding
  function automatic logic [17:0] bus_exp(input logic [17:0] c,
      input logic [1:0] m, input logic sb, input logic bs);
    logic [17:0] k;
    k = sb ? c : c ^ sar_ctrl_pkg::SIGN_FLIP;
    case (m)
      sar_ctrl_pkg::MODE_P18: return c;
      sar_ctrl_pkg::MODE_P16: return {2'h0, k[17:2]};
      sar_ctrl_pkg::MODE_P8: return {10'h000, bs ? k[9:2] : k[17:10]};
      default: return 18'h00000;
    endcase
  endfunction
  // one start pulse, a second request and power down while busy
  task automatic convert(input logic c);
    int n;
    @(negedge clk_sys);
    cmp_in = c;
    convert_start_n = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    check(18'(n), 18'h00003);
    check(18'(sample_switch_closed), 18'h00000);
    convert_start_n = 1'b1;
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
      if (n == 5) convert_start_n = 1'b0;
      if (n == 7) power_down_input = 1'b1;
      if (n == 8) convert_start_n = 1'b1;
    end
    power_down_input = 1'b0;
    check(18'(n), 18'h00013);
    repeat (6) @(negedge clk_sys);
    check(18'(busy), 18'h00000);
    check(18'(sample_switch_closed), 18'h00001);
  endtask
  initial begin
    lfsr = 32'h0E25;
    {rst_n, power_down_input, cmp_in, byte_swap} = 4'h0;
    {convert_start_n, ref_buffer_power_down, coding_select} = 3'h7;
    {interface_sel_1, interface_sel_0} = 2'h0;
    speed_mode = sar_ctrl_pkg::SPEED_NORMAL;
    prev = 18'h00000;
    repeat (10) @(negedge clk_sys);
    check(18'({busy, data_oe[0], sample_switch_closed, ref_buf_enable}),
      18'h00002);
    rst_n = 1'b1;
    for (int k = 0; k < 2; k++) begin
      ref_buffer_power_down = k[0];
      repeat (5) @(negedge clk_sys);
      check(18'(ref_buf_enable), 18'(!k[0]));
    end
    $display("reset and buffer test done");
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_step(lfsr);
      md = 2'(i);
      {interface_sel_1, interface_sel_0} = md;
      {coding_select, byte_swap} = lfsr[2:1];
      code = lfsr[0] ? 18'h3FFFF : 18'h00000;
      fork
        convert(lfsr[0]);
        begin
          repeat (4) @(negedge clk_sys);
          host.read(rd_d, rd_oe);
        end
      join
      if (i > 0 && md != sar_ctrl_pkg::MODE_SER)
        check(rd_d, bus_exp(prev, md, coding_select, byte_swap));
      host.read(rd_d, rd_oe);
      check(rd_oe, md == sar_ctrl_pkg::MODE_SER ? 18'h0 : 18'h3FFFF);
      if (md != sar_ctrl_pkg::MODE_SER)
        check(rd_d, bus_exp(code, md, coding_select, byte_swap));
      check(18'(busy), 18'h00000);
      repeat (4) @(negedge clk_sys);
      check(data_oe, 18'h00000);
      prev = code;
    end
    $display("conversion and readout test done");
    for (int k = 0; k < 2; k++) begin
      speed_mode = k ? sar_ctrl_pkg::SPEED_IMPULSE : sar_ctrl_pkg::SPEED_WARP;
      repeat (4) @(negedge clk_sys);
      convert_start_n = 1'b0;
      {nb, was, lp} = 0;
      repeat (120) begin
        @(negedge clk_sys);
        if (busy === 1'b1 && !was) nb++;
        if (busy === 1'b0 && core_low_power === 1'b1) lp = 1'b1;
        was = busy;
      end
      check(18'(nb > 2), 18'(k));
      check(18'(lp), 18'(k));
      convert_start_n = 1'b1;
      repeat (40) @(negedge clk_sys);
    end
    $display("self restart test done");
    end_of_test();
  end
endmodule
